// *** src/gpio_mode_function_mux.sv ***
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Programmed pin modes act only once the reset sequence has finished.
// - General input mirrors the synchronised pin into a readable register; default mode.
// - General output drives the pin from a host-written register bit.
// - Pins with identical alarm settings present identical output values.
// - Signal-absent mode drives high on the selected monitor alarm, invertible.
// - Signal-absent output follows the monitor live, never latched.
// - Live lock mode drives high whenever the chosen loop is unlocked.
// - Latched lock mode asserts when the loop enters or leaves lock.
// - Latched indications hold until the host clears them; polarity invertible.
// - Live holdover mode drives high while the chosen loop is in holdover.
// - Latched holdover mode asserts when the loop enters or leaves holdover.
// - Alert mode drives the OR of enabled sticky bits, active high, invertible.
// - Output-disable mode: high pin disables chosen output clocks, low enables.
// - Each disable pin acts on any chosen subset of output clocks.
// - Single-ended clock mode is refused on stages already fed by two references.
// - Manual select: asserted pin picks higher-priority input, else lower.
// - Step modes: each rising edge makes one increment or decrement pulse.
// - Disqualify mode: high pin disqualifies the preconfigured reference.
// - Per-pin enable; output modes choose open-drain or push-pull drive.
// - Each pin selects pull-up, the reset default, or pull-down.
// - A sticky bit sets on any live change and holds until cleared.
module gpio_mode_function_mux (
  input  wire logic                                     clk_sys,
  input  wire logic                                     reset,
  input  wire logic                                     init_done,
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [11:0]                              paddr,
  input  wire logic [31:0]                              pwdata,
  output logic      [31:0]                              prdata,
  output logic                                          pready,
  output logic                                          pslverr,
  input  wire logic [gpio_mux_pkg::NUM_PINS-1:0]        pin_i,
  output logic      [gpio_mux_pkg::NUM_PINS-1:0]        pin_o,
  output logic      [gpio_mux_pkg::NUM_PINS-1:0]        pin_oe,
  output logic      [gpio_mux_pkg::NUM_PINS-1:0]        pin_pull_up,
  output logic      [gpio_mux_pkg::NUM_PINS-1:0]        pin_pull_down,
  input  wire logic [gpio_mux_pkg::NUM_MON-1:0]         signal_absent,
  input  wire logic [gpio_mux_pkg::NUM_LOOP-1:0]        digital_lock_loop_locked,
  input  wire logic                                     analog_lock_loop_locked,
  input  wire logic [gpio_mux_pkg::NUM_LOOP-1:0]        digital_lock_loop_holdover,
  input  wire logic [gpio_mux_pkg::NUM_STAGE-1:0]       stage_two_se_refs,
  output logic      [gpio_mux_pkg::NUM_OUTCLK-1:0]      outclk_disable,
  output logic      [gpio_mux_pkg::NUM_STAGE-1:0]       se_clk_accept,
  output logic      [gpio_mux_pkg::NUM_LOOP-1:0]        ref_sel_high,
  output logic      [gpio_mux_pkg::NUM_NCO-1:0]         numeric_oscillator_inc,
  output logic      [gpio_mux_pkg::NUM_NCO-1:0]         numeric_oscillator_dec,
  output logic      [gpio_mux_pkg::NUM_LOOP-1:0]        ref_disqualify
);

  localparam int unsigned NP = gpio_mux_pkg::NUM_PINS;
  localparam int unsigned NL = gpio_mux_pkg::NUM_LOOP;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ACCESS = 2'b10
  } bus_state_e;

  bus_state_e        bus_q;
  logic [31:0]       global_q;
  logic [NP-1:0]     out_val_q;
  logic [NP-1:0]     in_mirror_q;
  logic [31:0]       cfg_q    [NP];
  logic [NP-1:0]     outsel_q [NP];
  logic [15:0]       alert_en_q;
  logic [3:0]        sticky_q;
  logic [3:0]        live_prev_q;
  logic              active_q;
  logic [NP-1:0]     pin_lvl;
  logic [NP-1:0]     pin_rise;
  logic [3:0]        live_alarm;
  logic [3:0]        sticky_clr;
  logic              alert_or;
  logic              wr_en;
  logic              rd_en;
  logic              pin_hit;
  logic [3:0]        pin_idx;
  logic [1:0]        pin_word;
  logic [11:0]       outclk_dis_d;

  // Synchroniser per pin; step modes use the edge pulse
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_sync
      gpio_pin_sync u_sync (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .pin_in     (pin_i[g]),
        .level_q    (pin_lvl[g]),
        .rise_pulse (pin_rise[g])
      );
    end
  endgenerate

  // Modes stay inert until the reset sequence reports done
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      active_q <= 1'b0;
    end else if (init_done) begin
      active_q <= 1'b1;
    end
  end

  // Live alarms: lock loss needs both loops' lock, holdover from the loop
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      live_alarm[gpio_mux_pkg::STK_LOCK_LSB + i] =
        ~(digital_lock_loop_locked[i] & analog_lock_loop_locked);
      live_alarm[gpio_mux_pkg::STK_HOLD_LSB + i] = digital_lock_loop_holdover[i];
    end
  end

  // Disable set is built in one pass so several pins can share clocks
  always_comb begin
    outclk_dis_d = '0;
    for (int p = 0; p < NP; p++) begin
      if (cfg_q[p][gpio_mux_pkg::CFG_MODE_LSB +: 4] == gpio_mux_pkg::MODE_OUT_DIS &&
          cfg_q[p][gpio_mux_pkg::CFG_ENABLE] && active_q && pin_lvl[p]) begin
        outclk_dis_d = outclk_dis_d | outsel_q[p][11:0];
      end
    end
  end

  // APB decode; single wait-free access phase
  assign pin_hit  = (paddr[11:8] == gpio_mux_pkg::ADDR_PIN_BASE[11:8]); // All sixteen pin blocks
  assign pin_idx  = paddr[gpio_mux_pkg::PIN_STRIDE_LOG +: 4];
  assign pin_word = paddr[3:2];
  assign wr_en    = psel & penable & pwrite & (bus_q == BUS_ACCESS);
  assign rd_en    = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_q <= BUS_IDLE;
    end else begin
      unique case (bus_q)
        BUS_IDLE:   bus_q <= (psel && !penable) ? BUS_ACCESS : BUS_IDLE;
        BUS_ACCESS: bus_q <= BUS_IDLE;
      endcase
    end
  end

  // Unmapped addresses answer with an error on the access phase
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        gpio_mux_pkg::ADDR_GLOBAL, gpio_mux_pkg::ADDR_PIN_IN, gpio_mux_pkg::ADDR_PIN_OUT,
        gpio_mux_pkg::ADDR_STICKY, gpio_mux_pkg::ADDR_ALERT_EN, gpio_mux_pkg::ADDR_STAGE_SE,
        gpio_mux_pkg::ADDR_LIVE: pslverr = 1'b0;
        default: pslverr = !(pin_hit && pin_word[1] == 1'b0);
      endcase
    end
  end

  // Sticky clears are write-one-to-clear pulses
  assign sticky_clr = (wr_en && paddr == gpio_mux_pkg::ADDR_STICKY) ? pwdata[3:0] : 4'h0;

  // Global, output value and alert-enable registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      global_q   <= gpio_mux_pkg::GLOBAL_RESET;
      out_val_q  <= '0;
      alert_en_q <= '0;
    end else if (wr_en) begin
      if (paddr == gpio_mux_pkg::ADDR_GLOBAL) global_q <= pwdata;
      if (paddr == gpio_mux_pkg::ADDR_PIN_OUT) out_val_q <= pwdata[NP-1:0];
      if (paddr == gpio_mux_pkg::ADDR_ALERT_EN) alert_en_q <= pwdata[15:0];
    end
  end

  // Per-pin configuration; single-ended clock requests are checked here
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int p = 0; p < NP; p++) begin
        cfg_q[p]    <= gpio_mux_pkg::CFG_RESET;
        outsel_q[p] <= '0;
      end
    end else if (wr_en && pin_hit) begin
      if (pin_word == gpio_mux_pkg::PIN_CFG_WORD) begin
        cfg_q[pin_idx] <= pwdata;
        // Refused mode falls back to general input and flags the refusal
        if (pwdata[gpio_mux_pkg::CFG_MODE_LSB +: 4] == gpio_mux_pkg::MODE_SE_CLK &&
            stage_two_se_refs[pwdata[gpio_mux_pkg::CFG_SRC_LSB]]) begin
          cfg_q[pin_idx][gpio_mux_pkg::CFG_MODE_LSB +: 4] <= gpio_mux_pkg::MODE_GP_IN;
          cfg_q[pin_idx][gpio_mux_pkg::CFG_REJECTED]      <= 1'b1;
        end else begin
          cfg_q[pin_idx][gpio_mux_pkg::CFG_REJECTED] <= 1'b0;
        end
      end else if (pin_word == gpio_mux_pkg::PIN_OUTSEL_WORD) begin
        outsel_q[pin_idx] <= pwdata[NP-1:0];
      end
    end
  end

  // Input mirror register for software reads
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_mirror_q <= '0;
    end else begin
      in_mirror_q <= pin_lvl;
    end
  end

  // Sticky bits: set on any live edge, set wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sticky_q    <= '0;
      live_prev_q <= live_alarm; // No false change on leaving reset
    end else begin
      live_prev_q <= live_alarm;
      sticky_q    <= (sticky_q & ~sticky_clr) | (live_alarm ^ live_prev_q);
    end
  end

  // Alert is gated by the global alarm enable
  assign alert_or = global_q[gpio_mux_pkg::GLB_ALARM_EN] & |(sticky_q & alert_en_q[3:0]);

  // Register read data
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= '0;
    end else if (rd_en) begin
      prdata <= '0;
      unique case (paddr)
        gpio_mux_pkg::ADDR_GLOBAL:   prdata <= global_q;
        gpio_mux_pkg::ADDR_PIN_IN:   prdata[NP-1:0] <= in_mirror_q;
        gpio_mux_pkg::ADDR_PIN_OUT:  prdata[NP-1:0] <= out_val_q;
        gpio_mux_pkg::ADDR_STICKY:   prdata[3:0] <= sticky_q;
        gpio_mux_pkg::ADDR_ALERT_EN: prdata[15:0] <= alert_en_q;
        gpio_mux_pkg::ADDR_LIVE:     prdata[3:0] <= live_alarm;
        default: begin
          if (pin_hit && pin_word == gpio_mux_pkg::PIN_CFG_WORD) prdata <= cfg_q[pin_idx];
          else if (pin_hit && pin_word == gpio_mux_pkg::PIN_OUTSEL_WORD) prdata[NP-1:0] <= outsel_q[pin_idx];
        end
      endcase
    end
  end

  // Per-pin output mux and control fan-out; registered so all pins line up
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_o                  <= '0;
      pin_oe                 <= '0;
      pin_pull_up            <= '1;
      pin_pull_down          <= '0;
      outclk_disable         <= '0;
      se_clk_accept          <= '0;
      ref_sel_high           <= '0;
      numeric_oscillator_inc <= '0;
      numeric_oscillator_dec <= '0;
      ref_disqualify         <= '0;
    end else begin
      outclk_disable         <= outclk_dis_d;
      se_clk_accept          <= '0;
      ref_sel_high           <= '0;
      numeric_oscillator_inc <= '0;
      numeric_oscillator_dec <= '0;
      ref_disqualify         <= '0;
      for (int p = 0; p < NP; p++) begin
        logic [3:0] mode;
        logic [3:0] src;
        logic       en;
        logic       inv;
        logic       drives;
        logic       val;
        mode   = cfg_q[p][gpio_mux_pkg::CFG_MODE_LSB +: 4];
        src    = cfg_q[p][gpio_mux_pkg::CFG_SRC_LSB +: 4];
        en     = cfg_q[p][gpio_mux_pkg::CFG_ENABLE] & active_q;
        inv    = cfg_q[p][gpio_mux_pkg::CFG_INVERT];
        drives = 1'b1;
        val    = 1'b0;
        unique case (mode)
          gpio_mux_pkg::MODE_GP_OUT:    val = out_val_q[p];
          gpio_mux_pkg::MODE_SIG_ABS:   val = signal_absent[src[1:0]] ^ inv;
          gpio_mux_pkg::MODE_LOCK_LIVE: val = live_alarm[gpio_mux_pkg::STK_LOCK_LSB + src[0]] ^ inv;
          gpio_mux_pkg::MODE_LOCK_LAT:  val = sticky_q[gpio_mux_pkg::STK_LOCK_LSB + src[0]] ^ inv;
          gpio_mux_pkg::MODE_HOLD_LIVE: val = live_alarm[gpio_mux_pkg::STK_HOLD_LSB + src[0]] ^ inv;
          gpio_mux_pkg::MODE_HOLD_LAT:  val = sticky_q[gpio_mux_pkg::STK_HOLD_LSB + src[0]] ^ inv;
          gpio_mux_pkg::MODE_ALERT:     val = alert_or ^ inv;
          default:                      drives = 1'b0;
        endcase
        // Input-mode functions only act on enabled pins
        if (en) begin
          unique case (mode)
            gpio_mux_pkg::MODE_SE_CLK:  se_clk_accept[src[0]] <= 1'b1;
            gpio_mux_pkg::MODE_MAN_SEL: ref_sel_high[src[0]] <= pin_lvl[p];
            gpio_mux_pkg::MODE_NCO_INC: if (pin_rise[p] && src < 4'h6) numeric_oscillator_inc[src[2:0]] <= 1'b1;
            gpio_mux_pkg::MODE_NCO_DEC: if (pin_rise[p] && src < 4'h6) numeric_oscillator_dec[src[2:0]] <= 1'b1;
            gpio_mux_pkg::MODE_DISQUAL: if (pin_lvl[p]) ref_disqualify[src[0]] <= 1'b1;
            default: ;
          endcase
        end
        // Open drain drives only the low level
        if (cfg_q[p][gpio_mux_pkg::CFG_OPEN_DRAIN]) begin
          pin_o[p]  <= 1'b0;
          pin_oe[p] <= en & drives & ~val;
        end else begin
          pin_o[p]  <= val;
          pin_oe[p] <= en & drives;
        end
        pin_pull_up[p]   <= ~cfg_q[p][gpio_mux_pkg::CFG_PULL_DOWN];
        pin_pull_down[p] <= cfg_q[p][gpio_mux_pkg::CFG_PULL_DOWN];
      end
    end
  end

endmodule

// *** src/gpio_mux_pkg.sv ***
package gpio_mux_pkg;

  // Pin count and source counts
  localparam int unsigned NUM_PINS    = 16;
  localparam int unsigned NUM_MON     = 4;
  localparam int unsigned NUM_LOOP    = 2;
  localparam int unsigned NUM_OUTCLK  = 12;
  localparam int unsigned NUM_NCO     = 6;
  localparam int unsigned NUM_STAGE   = 2;
  localparam int unsigned ALERT_SRCS  = 16;

  // Mode codes held in the per-pin mode field
  localparam logic [3:0] MODE_GP_IN     = 4'h0;
  localparam logic [3:0] MODE_GP_OUT    = 4'h1;
  localparam logic [3:0] MODE_SIG_ABS   = 4'h2;
  localparam logic [3:0] MODE_LOCK_LIVE = 4'h3;
  localparam logic [3:0] MODE_LOCK_LAT  = 4'h4;
  localparam logic [3:0] MODE_HOLD_LIVE = 4'h5;
  localparam logic [3:0] MODE_HOLD_LAT  = 4'h6;
  localparam logic [3:0] MODE_ALERT     = 4'h7;
  localparam logic [3:0] MODE_OUT_DIS   = 4'h8;
  localparam logic [3:0] MODE_SE_CLK    = 4'h9;
  localparam logic [3:0] MODE_MAN_SEL   = 4'hA;
  localparam logic [3:0] MODE_NCO_INC   = 4'hB;
  localparam logic [3:0] MODE_NCO_DEC   = 4'hC;
  localparam logic [3:0] MODE_DISQUAL   = 4'hD;

  // Register map: global registers, then one block of words per pin
  localparam logic [11:0] ADDR_GLOBAL    = 12'h000;
  localparam logic [11:0] ADDR_PIN_IN    = 12'h004;
  localparam logic [11:0] ADDR_PIN_OUT   = 12'h008;
  localparam logic [11:0] ADDR_STICKY    = 12'h00C;
  localparam logic [11:0] ADDR_ALERT_EN  = 12'h010;
  localparam logic [11:0] ADDR_STAGE_SE  = 12'h014;
  localparam logic [11:0] ADDR_LIVE      = 12'h018;
  localparam logic [11:0] ADDR_PIN_BASE  = 12'h100;
  localparam int unsigned PIN_STRIDE_LOG = 4;
  localparam logic [1:0]  PIN_CFG_WORD   = 2'h0;
  localparam logic [1:0]  PIN_OUTSEL_WORD = 2'h1;

  // Global register fields
  localparam int unsigned GLB_SUPPLY_LSB = 0;
  localparam logic [1:0]  SUPPLY_1V8     = 2'h1;
  localparam int unsigned GLB_ALARM_EN   = 4;

  // Per-pin configuration word fields
  localparam int unsigned CFG_MODE_LSB   = 0;
  localparam int unsigned CFG_SRC_LSB    = 4;
  localparam int unsigned CFG_ENABLE     = 8;
  localparam int unsigned CFG_INVERT     = 9;
  localparam int unsigned CFG_OPEN_DRAIN = 10;
  localparam int unsigned CFG_PULL_DOWN  = 11;
  localparam int unsigned CFG_REJECTED   = 12;

  // Reset values
  localparam logic [31:0] CFG_RESET      = 32'h0000_0100;
  localparam logic [31:0] GLOBAL_RESET   = 32'h0000_0011;

  // Sticky bit positions: lock then holdover per loop
  localparam int unsigned STK_LOCK_LSB   = 0;
  localparam int unsigned STK_HOLD_LSB   = 2;

endpackage

// *** src/gpio_pin_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser plus rising-edge detector for one pin
module gpio_pin_sync (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      level_q,
  output logic      rise_pulse
);

  logic meta_q;
  logic prev_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Start at the pulled-up idle level so leaving reset is never seen as a rise
      meta_q  <= 1'b1;
      level_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      meta_q  <= pin_in;
      level_q <= meta_q;
      prev_q  <= level_q;
    end
  end

  // One pulse per rising edge of the settled level
  assign rise_pulse = level_q & ~prev_q;

endmodule

// *** sim/gpio_mux_assertions.sv ***
`timescale 1ns/1ps
// Watches the mux top ports only; pin and source checks tie outputs to their causes
module gpio_mux_checker (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        init_done,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [15:0] pin_i,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pin_pull_up,
  input  wire logic [15:0] pin_pull_down,
  input  wire logic [1:0]  stage_two_se_refs,
  input  wire logic [11:0] outclk_disable,
  input  wire logic [1:0]  se_clk_accept,
  input  wire logic [5:0]  numeric_oscillator_inc,
  input  wire logic [5:0]  numeric_oscillator_dec
);
  logic        init_seen_q;
  logic [15:0] pin_prev_q;
  logic [3:0]  since_rise_q;
  logic [3:0]  since_high_q;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Ages of the last pin rise and pin high, saturating so old activity never excuses an output
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      init_seen_q  <= 1'b0;
      pin_prev_q   <= '0;
      since_rise_q <= 4'hF;
      since_high_q <= 4'hF;
    end else begin
      init_seen_q  <= init_seen_q | init_done;
      pin_prev_q   <= pin_i;
      since_rise_q <= (|(pin_i & ~pin_prev_q)) ? 4'h0 : (since_rise_q == 4'hF ? 4'hF : since_rise_q + 4'h1);
      since_high_q <= (|pin_i) ? 4'h0 : (since_high_q == 4'hF ? 4'hF : since_high_q + 4'h1);
    end
  end
  property p_reset_vals;
    disable iff (1'b0) reset |=> pin_oe == '0 && pin_pull_up == '1 && pin_pull_down == '0 && prdata == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("pins not at reset values");
  property p_inert;
    !init_seen_q |-> pin_oe == '0 && outclk_disable == '0;
  endproperty
  a_inert: assert property (p_inert)
    else $error("pin function active before init");
  property p_pulse;
    |numeric_oscillator_inc |=> (numeric_oscillator_inc & $past(numeric_oscillator_inc)) == '0;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("step pulse longer than one cycle");
  property p_step_cause;
    (|numeric_oscillator_inc || |numeric_oscillator_dec) |-> since_rise_q <= 4'h8;
  endproperty
  a_step_cause: assert property (p_step_cause)
    else $error("step pulse without a pin rise");
  property p_outdis_cause;
    (outclk_disable & ~$past(outclk_disable)) != '0 |-> since_high_q <= 4'h6;
  endproperty
  a_outdis_cause: assert property (p_outdis_cause)
    else $error("clock disabled without a high pin");
  property p_pready;
    psel && penable |-> pready;
  endproperty
  a_pready: assert property (p_pready)
    else $error("access phase not answered");
  property p_slverr;
    pslverr |-> psel && penable;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("error outside access phase");
  property p_pull;
    (pin_pull_up ^ pin_pull_down) == '1;
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull selection not exclusive");
  property p_se;
    (se_clk_accept & $past(stage_two_se_refs)) == '0;
  endproperty
  a_se: assert property (p_se)
    else $error("single-ended clock accepted on full stage");
endmodule

bind gpio_mode_function_mux gpio_mux_checker chk_u (
  .clk_sys(clk_sys), .reset(reset), .init_done(init_done), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_oe(pin_oe),
  .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .stage_two_se_refs(stage_two_se_refs),
  .outclk_disable(outclk_disable), .se_clk_accept(se_clk_accept),
  .numeric_oscillator_inc(numeric_oscillator_inc), .numeric_oscillator_dec(numeric_oscillator_dec)
);

// *** sim/gpio_board_model.sv ***
`timescale 1ns/1ps
// Board side of the pins: resolves each wire from all drivers and pulls
module gpio_board_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] pin_o,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pin_pull_up,
  input  wire logic [15:0] pin_pull_down,
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_oe,
  output logic      [15:0] pin_i
);
  logic [15:0] last_q;
  // A pin with no driver and no pull flips, so a stale level is never trusted
  always_ff @(posedge clk_sys) begin
    last_q <= pin_i;
  end
  // Device driver first, then the board source, then the weak pulls
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      if (pin_oe[p])
        pin_i[p] = pin_o[p];
      else if (ext_oe[p])
        pin_i[p] = ext_val[p];
      else if (pin_pull_up[p])
        pin_i[p] = 1'b1;
      else if (pin_pull_down[p])
        pin_i[p] = 1'b0;
      else
        pin_i[p] = ~last_q[p];
    end
  end
endmodule

// *** sim/test_gpio_mode_function_mux.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module test_gpio_mode_function_mux;
  logic        clk_sys = 1'b0, reset = 1'b1, init_done = 1'b0, analog_lock_loop_lk = 1'b0, last_err = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [15:0] pin_i, pin_o, pin_oe, pull_up, pull_dn, ext_val = '0, ext_oe = 16'h0F32;
  logic [3:0]  sig_abs = '0;
  logic [1:0]  dll_lk = '0, hold = '0, stage_se = 2'h1, se_acc, ref_sel, ref_dq;
  logic [11:0] outclk_disable;
  logic [5:0]  nco_inc, nco_dec;
  int          bad_count = 0, checked = 0, inc_cnt = 0, dec_cnt = 0, sticky_m = 0;

  gpio_mode_function_mux dut_u (.clk_sys(clk_sys), .reset(reset), .init_done(init_done), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pull_up(pull_up),
    .pin_pull_down(pull_dn), .signal_absent(sig_abs), .digital_lock_loop_locked(dll_lk),
    .analog_lock_loop_locked(analog_lock_loop_lk), .digital_lock_loop_holdover(hold), .stage_two_se_refs(stage_se),
    .outclk_disable(outclk_disable), .se_clk_accept(se_acc), .ref_sel_high(ref_sel),
    .numeric_oscillator_inc(nco_inc), .numeric_oscillator_dec(nco_dec), .ref_disqualify(ref_dq));
  gpio_board_model board_u (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pull_up(pull_up),
    .pin_pull_down(pull_dn), .ext_val(ext_val), .ext_oe(ext_oe), .pin_i(pin_i));

  // 25 MHz core clock
  always #20 clk_sys = ~clk_sys;
  // Step pulses seen on the channels under test
  always @(posedge clk_sys) begin
    inc_cnt += nco_inc[3];
    dec_cnt += nco_dec[5];
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic settle();
    repeat (5) @(posedge clk_sys);
  endtask
  // New random sources; the sticky model marks every live change
  task automatic set_src();
    logic [3:0] sa;
    logic [1:0] lk, hd;
    logic       ap;
    sa = 4'($urandom);
    lk = 2'($urandom);
    hd = 2'($urandom);
    ap = 1'($urandom);
    for (int l = 0; l < 2; l++) begin
      if (!(dll_lk[l] && analog_lock_loop_lk) != !(lk[l] && ap)) sticky_m |= 1 << l;
      if (hold[l] != hd[l]) sticky_m |= 4 << l;
    end
    @(posedge clk_sys);
    sig_abs <= sa;
    dll_lk <= lk;
    hold <= hd;
    analog_lock_loop_lk <= ap;
    settle();
  endtask
  function automatic logic exp_alarm(int m, int s, int en);
    case (m)
      2: return sig_abs[s];
      3: return !(dll_lk[s] && analog_lock_loop_lk);
      4: return sticky_m[s];
      5: return hold[s];
      6: return sticky_m[2 + s];
      default: return |(sticky_m & en);
    endcase
  endfunction

  initial begin
    logic [31:0] r;
    int          s, inv, en, v, a, b, c0, d0;
    r = $urandom(32'h838B);
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values and the host's supply setting
    apb(1'b0, 12'h000, '0, r); `CHK(r, gpio_mux_pkg::GLOBAL_RESET)
    apb(1'b0, 12'h100, '0, r); `CHK(r, gpio_mux_pkg::CFG_RESET)
    `CHK(pull_up, 16'hFFFF)
    wr(12'h000, 32'h11);
    // Output mode stays inert until init is done
    wr(12'h100, 32'h101);
    wr(12'h008, 32'h1);
    settle(); `CHK(pin_oe[0], 1'b0)
    init_done <= 1'b1;
    settle(); `CHK(pin_oe[0], 1'b1)
    // General output, push-pull or open-drain, then a disabled pin
    for (int k = 0; k < 4; k++) begin
      v = $urandom % 2;
      a = $urandom % 2;
      wr(12'h100, 32'(32'h101 | (a << 10)));
      wr(12'h008, 32'(v));
      settle(); `CHK(pin_i[0], v[0])
      `CHK(pin_oe[0], (a != 0) ? ~v[0] : 1'b1)
    end
    wr(12'h100, 32'h001);
    settle(); `CHK(pin_oe[0], 1'b0)
    // General input mirror
    for (int k = 0; k < 4; k++) begin
      ext_val <= 16'($urandom);
      settle();
      apb(1'b0, 12'h004, '0, r); `CHK(r[1], ext_val[1])
    end
    // Alarm modes on pins 2 and 3 set alike, live and latched, with clears
    wr(12'h00C, 32'hF);
    sticky_m = 0;
    for (int m = 2; m <= 7; m++) begin
      for (int k = 0; k < 4; k++) begin
        s = $urandom % ((m == 2) ? 4 : 2);
        inv = $urandom % 2;
        en = $urandom % 16;
        wr(12'h010, 32'(en));
        for (int p = 2; p < 4; p++) wr(12'(12'h100 + p * 16), 32'(m | (s << 4) | (inv << 9) | 32'h100));
        set_src();
        `CHK(pin_o[2], exp_alarm(m, s, en) ^ inv[0])
        `CHK(pin_o[3], exp_alarm(m, s, en) ^ inv[0])
        apb(1'b0, 12'h00C, '0, r); `CHK(r[3:0], sticky_m[3:0])
        if (k == 3) begin
          wr(12'h00C, 32'(sticky_m));
          sticky_m = 0;
          settle(); `CHK(pin_o[2], exp_alarm(m, s, en) ^ inv[0])
        end
      end
    end
    // Output disable sets, manual select and disqualify follow their pins
    a = $urandom % 4096;
    b = $urandom % 4096;
    wr(12'h144, 32'(a));
    wr(12'h154, 32'(b));
    wr(12'h140, 32'h108);
    wr(12'h150, 32'h108);
    wr(12'h180, 32'h11A);
    wr(12'h190, 32'h10D);
    for (int k = 0; k < 6; k++) begin
      ext_val <= 16'($urandom);
      settle(); `CHK(outclk_disable, (ext_val[4] ? a[11:0] : 12'h0) | (ext_val[5] ? b[11:0] : 12'h0))
      `CHK(ref_sel[1], ext_val[8])
      `CHK(ref_dq[0], ext_val[9])
    end
    // Single-ended clock refused on the stage that already has two references
    wr(12'h160, 32'h109);
    wr(12'h170, 32'h119);
    settle();
    apb(1'b0, 12'h160, '0, r); `CHK(r, 32'h1100)
    apb(1'b0, 12'h170, '0, r); `CHK(r, 32'h119)
    `CHK(se_acc, 2'b10)
    // Three rises step up, two step down
    wr(12'h1A0, 32'h13B);
    wr(12'h1B0, 32'h15C);
    ext_val[11:10] <= 2'b00;
    settle();
    c0 = inc_cnt;
    d0 = dec_cnt;
    for (int k = 0; k < 3; k++) begin
      ext_val[11:10] <= {(k < 2), 1'b1};
      repeat (4) @(posedge clk_sys);
      ext_val[11:10] <= 2'b00;
      repeat (4) @(posedge clk_sys);
    end
    settle(); `CHK(inc_cnt - c0, 3)
    `CHK(dec_cnt - d0, 2)
    // Pull-down on a floating pin, then an unmapped read
    wr(12'h1C0, 32'h900);
    settle(); `CHK(pin_i[12], 1'b0)
    apb(1'b0, 12'h0FC, '0, r); `CHK(last_err, 1'b1)
    stop_test();
  end
endmodule
